// ---- src/icsm_pkg.sv ----
package icsm_pkg;
    // register byte offsets
    localparam logic [7:0] ICSM_CTRL_OFF = 8'h00;
    localparam logic [7:0] ICSM_INCFG_OFF = 8'h04;
    localparam logic [7:0] ICSM_PRIO_OFF = 8'h08;
    localparam logic [7:0] ICSM_LOSLIM_OFF = 8'h0c;
    localparam logic [7:0] ICSM_OOFRNG_OFF = 8'h10;
    localparam logic [7:0] ICSM_PULLIN_OFF = 8'h14;
    localparam logic [7:0] ICSM_STATUS_OFF = 8'h18;
    localparam logic [7:0] ICSM_STICKY_OFF = 8'h1c;
    // control register fields
    localparam int CTRL_SEL_REG = 0;
    localparam int CTRL_MSEL_LO = 1;
    localparam int CTRL_AUTO = 3;
    localparam int CTRL_REVERT = 4;
    localparam int CTRL_ZDM = 5;
    localparam int CTRL_HITLESS = 6;
    localparam int CTRL_RAMP = 7;
    localparam int CTRL_FASTLOCK = 8;
    localparam int CTRL_KEEP_OUT = 9;
    localparam int CTRL_REF_LO = 10;
    // input configuration fields, four bits each
    localparam int INCFG_EN_LO = 0;
    localparam int INCFG_DIFF_LO = 4;
    localparam int INCFG_LOS_LO = 8;
    localparam int INCFG_PREC_LO = 12;
    localparam int INCFG_FAST_LO = 16;
    // frequency range fields
    localparam int OOFRNG_HYST_LO = 16;
    localparam int PULLIN_RAMP_LO = 16;
    // status / sticky fields
    localparam int ST_LOS_LO = 0;
    localparam int ST_REFLOS = 4;
    localparam int ST_OOF_LO = 5;
    localparam int ST_ACT_LO = 9;
    localparam int ST_LOL = 11;
    localparam int ST_HOLD = 12;
    localparam int ST_FREE = 13;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0080;
    localparam logic [31:0] INCFG_RST = 32'h0000_0f0f;
    localparam logic [31:0] PRIO_RST = 32'h0000_00e4;
    localparam logic [31:0] LOSLIM_RST = 32'h2020_2020;
    localparam logic [31:0] OOFRNG_RST = 32'h0020_0060;
    localparam logic [31:0] PULLIN_RST = 32'h0400_0100;
    // monitor constants
    localparam logic [7:0] XTAL_LOS_LIMIT = 8'h10;
    localparam int FAST_EDGES = 1024;
    localparam longint PPM_SCALE = 1000000;
    localparam longint PREC_STEPS_PER_PPM = 16;
    localparam longint FAST_LIMIT_PPM = 4000;
    localparam longint PRECISE_MAX_RANGE = 8000;
    // timing
    localparam int CLK_MHZ = 20;
    localparam int FAST_PULLIN_US = 10;
    localparam int FAST_PULLIN_CYCLES = FAST_PULLIN_US * CLK_MHZ;
    typedef enum logic [3:0] {
        ST_FREERUN = 4'b0001,
        ST_ACQUIRE = 4'b0010,
        ST_LOCKED = 4'b0100,
        ST_HOLDOVER = 4'b1000
    } icsm_mode_e;
endpackage

// ---- src/icsm_top.sv ----
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
// Summary of operation
// - config bit picks pin or register select
// - select codes 0..3 pick inputs 0..3
// - zero delay mode excludes input 3
// - manual dead input forces freerun or holdover
// - automatic choice uses validity, priority, revertive
// - automatic with nothing valid enters holdover, or freerun if never locked
// - revertive always tracks best valid input
// - non-revertive keeps active input while valid
// - hitless switch absorbs phase when enabled
// - ramped switching shares holdover ramp setting
// - switch pulls in with normal/fast bandwidth
// - lock lost asserted throughout pull-in
// - per-input differential select and disable
// - tolerated gaps raise no faults
// - monitor all inputs and crystal reference
// - per-period loss check, per-input sensitivity
// - live and sticky loss bits, per-input monitor disable (crystal always on)
// - reference loss stops outputs unless overridden
// - frequency reference is crystal or any input
// - precise and fast monitors, live and sticky
// - precise window up to 500ppm, hysteresis
// - fast monitor flags over 4000 ppm
module icsm_top
    import icsm_pkg::*;
#(
    parameter int PREC_EDGES = 1048576
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_input_0,
    input wire logic clock_input_1,
    input wire logic clock_input_2,
    input wire logic clock_input_3,
    input wire logic crystal_reference_pins,
    input wire logic [1:0] manual_select_pins,
    output logic [1:0] selected_input,
    output logic lock_lost_flag,
    output logic holdover_mode,
    output logic freerun_mode,
    output logic phase_absorb,
    output logic ramp_switch,
    output logic fastlock_bw,
    output logic outputs_enable,
    output logic [3:0] input_enable,
    output logic [3:0] input_differential,
    output logic [3:0] signal_loss_flag,
    output logic reference_loss_flag,
    output logic [3:0] frequency_error_flag
);
    logic [31:0] ctrl_r, incfg_r, prio_r, loslim_r, oofrng_r, pullin_r;
    logic [8:0] sticky_r, sticky_nxt;
    logic [31:0] rdata_nxt;
    logic [4:0] s1_r, s2_r, s3_r;
    logic [1:0] msel1_r, msel2_r;
    logic [4:0] edge_w;
    logic [4:0] los_w;
    logic [3:0] oof_w, valid_w;
    logic [2:0] ref_sel;
    logic ref_edge;
    logic [23:0] win_r;
    logic prec_end, fast_end;
    icsm_mode_e mode_r, mode_nxt;
    logic [1:0] act_r, act_nxt;
    logic [15:0] pull_r, pull_nxt;
    logic once_r, hit_r, hit_nxt;

    // APB decode
    wire wr_en = psel & penable & pwrite;
    wire setup = psel & ~penable;
    wire mapped = (paddr[1:0] == 2'b00) && (paddr <= ICSM_STICKY_OFF);
    wire wr_ctrl = wr_en && paddr == ICSM_CTRL_OFF;
    wire wr_incfg = wr_en && paddr == ICSM_INCFG_OFF;
    wire wr_prio = wr_en && paddr == ICSM_PRIO_OFF;
    wire wr_loslim = wr_en && paddr == ICSM_LOSLIM_OFF;
    wire wr_oofrng = wr_en && paddr == ICSM_OOFRNG_OFF;
    wire wr_pullin = wr_en && paddr == ICSM_PULLIN_OFF;
    wire wr_sticky = wr_en && paddr == ICSM_STICKY_OFF;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire sel_from_reg = ctrl_r[CTRL_SEL_REG];
    wire auto_mode = ctrl_r[CTRL_AUTO];
    wire revertive = ctrl_r[CTRL_REVERT];
    wire zdm = ctrl_r[CTRL_ZDM];
    wire ramp_en = ctrl_r[CTRL_RAMP];
    wire fast_en = ctrl_r[CTRL_FASTLOCK];
    wire [3:0] in_en = incfg_r[INCFG_EN_LO +: 4];
    wire [3:0] los_en = incfg_r[INCFG_LOS_LO +: 4];
    wire [3:0] prec_en = incfg_r[INCFG_PREC_LO +: 4];
    wire [3:0] fmon_en = incfg_r[INCFG_FAST_LO +: 4];
    wire [12:0] oof_range = oofrng_r[12:0];
    wire [12:0] oof_hyst = oofrng_r[OOFRNG_HYST_LO +: 13];
    wire [12:0] oof_clear = (oof_hyst > oof_range) ? 13'h0000 :
                            oof_range - oof_hyst;

    // pins cross into pclk through two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 5'h00;
            s2_r <= 5'h00;
            s3_r <= 5'h00;
            msel1_r <= 2'h0;
            msel2_r <= 2'h0;
        end else begin
            s1_r <= {crystal_reference_pins, clock_input_3, clock_input_2,
                     clock_input_1, clock_input_0};
            s2_r <= s1_r;
            s3_r <= s2_r;
            msel1_r <= manual_select_pins;
            msel2_r <= msel1_r;
        end
    end
    assign edge_w = s2_r & ~s3_r;

    // loss-of-signal: cycles since last rising edge against a limit
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_los
            logic [7:0] cnt_r;
            logic los_r;
            wire [7:0] lim = (g < 4) ? loslim_r[8*(g%4) +: 8] :
                             XTAL_LOS_LIMIT;
            wire on = (g < 4) ? los_en[g%4] : 1'b1;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_r <= 8'h00;
                    los_r <= 1'b0;
                end else if (!on || edge_w[g]) begin
                    cnt_r <= 8'h00;
                    los_r <= 1'b0;
                end else if (cnt_r >= lim) begin
                    // only a gap longer than the limit counts
                    los_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
            assign los_w[g] = los_r;
        end
    endgenerate

    // frequency reference select: 0 crystal, 1..4 input 0..3
    assign ref_sel = ctrl_r[CTRL_REF_LO +: 3];
    assign ref_edge = (ref_sel == 3'h0 || ref_sel > 3'h4) ? edge_w[4] :
                      edge_w[2'(ref_sel - 3'h1)];
    assign prec_end = ref_edge && (win_r == 24'(PREC_EDGES - 1));
    assign fast_end = ref_edge && (win_r[9:0] == 10'(FAST_EDGES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_r <= 24'h00_0000;
        end else if (prec_end) begin
            win_r <= 24'h00_0000;
        end else if (ref_edge) begin
            win_r <= win_r + 24'h00_0001;
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : g_oof
            logic [23:0] pc_r;
            logic [11:0] fc_r;
            logic prec_r, fast_r;
            wire [23:0] pcur = pc_r + 24'(edge_w[g]);
            wire [11:0] fcur = fc_r + 12'(edge_w[g]);
            wire [23:0] pdev = (pcur > 24'(PREC_EDGES)) ?
                               pcur - 24'(PREC_EDGES) : 24'(PREC_EDGES) - pcur;
            wire [11:0] fdev = (fcur > 12'(FAST_EDGES)) ?
                               fcur - 12'(FAST_EDGES) : 12'(FAST_EDGES) - fcur;
            wire [63:0] pmeas = 64'(pdev) * 64'(PPM_SCALE * PREC_STEPS_PER_PPM);
            wire [12:0] rng = (oof_range > 13'(PRECISE_MAX_RANGE)) ?
                              13'(PRECISE_MAX_RANGE) : oof_range;
            wire [63:0] pset = 64'(rng) * 64'(PREC_EDGES);
            wire [63:0] pclr = 64'(oof_clear) * 64'(PREC_EDGES);
            wire fbad = 64'(fdev) * 64'(PPM_SCALE) >
                        64'(FAST_LIMIT_PPM * FAST_EDGES);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pc_r <= 24'h00_0000;
                    fc_r <= 12'h000;
                    prec_r <= 1'b0;
                    fast_r <= 1'b0;
                end else begin
                    pc_r <= prec_end ? 24'h00_0000 : pcur;
                    fc_r <= fast_end ? 12'h000 : fcur;
                    if (!prec_en[g]) begin
                        prec_r <= 1'b0;
                    end else if (prec_end && pmeas > pset) begin
                        prec_r <= 1'b1;
                    end else if (prec_end && pmeas <= pclr) begin
                        prec_r <= 1'b0;
                    end
                    if (!fmon_en[g]) begin
                        fast_r <= 1'b0;
                    end else if (fast_end) begin
                        fast_r <= fbad;
                    end
                end
            end
            assign oof_w[g] = prec_r | fast_r;
            // an input is usable only if enabled and free of faults
            assign valid_w[g] = in_en[g] & ~(los_w[g] & los_en[g]) &
                                ~oof_w[g] & ~(zdm && g == 3);
        end
    endgenerate

    // best valid input: lowest priority code, lowest index on ties
    logic [1:0] best;
    logic any_valid;
    always_comb begin
        best = 2'h0;
        any_valid = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (valid_w[i] && (!any_valid ||
                prio_r[2*i +: 2] < prio_r[2*best +: 2])) begin
                best = 2'(i);
                any_valid = 1'b1;
            end
        end
    end

    wire [1:0] msel = sel_from_reg ? ctrl_r[CTRL_MSEL_LO +: 2] : msel2_r;
    // code 3 is reserved under zero delay mode, never selected
    wire man_ok = !(zdm && msel == 2'h3) && valid_w[msel];
    wire engaged = (mode_r == ST_LOCKED) || (mode_r == ST_ACQUIRE);
    wire keep_act = !revertive && engaged && valid_w[act_r];
    wire [1:0] want = !auto_mode ? msel : keep_act ? act_r : best;
    wire want_ok = !auto_mode ? man_ok : any_valid;
    // ramp shares the holdover-exit ramp setting
    wire [15:0] pull_load = ramp_en ? pullin_r[PULLIN_RAMP_LO +: 16] :
                            fast_en ? 16'(FAST_PULLIN_CYCLES) :
                            pullin_r[15:0];
    wire [15:0] pull_min = (pull_load == 16'h0000) ? 16'h0001 : pull_load;

    always_comb begin
        mode_nxt = mode_r;
        act_nxt = act_r;
        pull_nxt = pull_r;
        hit_nxt = hit_r;
        case (mode_r)
            ST_FREERUN, ST_HOLDOVER, ST_ACQUIRE, ST_LOCKED: begin
                if (!want_ok) begin
                    // nothing usable: hold history if any, else free-run
                    mode_nxt = once_r ? ST_HOLDOVER : ST_FREERUN;
                    hit_nxt = 1'b0;
                end else if (!engaged || want != act_r) begin
                    mode_nxt = ST_ACQUIRE;
                    act_nxt = want;
                    pull_nxt = pull_min;
                    hit_nxt = engaged && ctrl_r[CTRL_HITLESS];
                end else if (mode_r == ST_ACQUIRE) begin
                    if (pull_r <= 16'h0001) begin
                        mode_nxt = ST_LOCKED;
                        hit_nxt = 1'b0;
                    end else begin
                        pull_nxt = pull_r - 16'h0001;
                    end
                end
            end
            default: begin
                mode_nxt = ST_FREERUN;
                hit_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= ST_FREERUN;
            act_r <= 2'h0;
            pull_r <= 16'h0000;
            hit_r <= 1'b0;
            once_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            act_r <= act_nxt;
            pull_r <= pull_nxt;
            hit_r <= hit_nxt;
            once_r <= once_r | (mode_nxt == ST_LOCKED);
        end
    end

    // sticky: hardware set wins over a same-cycle software clear
    wire [8:0] sticky_evt = {oof_w, los_w};
    assign sticky_nxt = sticky_evt |
                        (sticky_r & ~(wr_sticky ? pwdata[8:0] : 9'h000));

    wire [31:0] status_w = {18'h0_0000, mode_r == ST_FREERUN,
                            mode_r == ST_HOLDOVER, mode_r != ST_LOCKED,
                            act_r, oof_w, los_w};

    always_comb begin
        case (paddr)
            ICSM_CTRL_OFF: rdata_nxt = ctrl_r;
            ICSM_INCFG_OFF: rdata_nxt = incfg_r;
            ICSM_PRIO_OFF: rdata_nxt = prio_r;
            ICSM_LOSLIM_OFF: rdata_nxt = loslim_r;
            ICSM_OOFRNG_OFF: rdata_nxt = oofrng_r;
            ICSM_PULLIN_OFF: rdata_nxt = pullin_r;
            ICSM_STATUS_OFF: rdata_nxt = status_w;
            ICSM_STICKY_OFF: rdata_nxt = {23'h00_0000, sticky_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            incfg_r <= INCFG_RST;
            prio_r <= PRIO_RST;
            loslim_r <= LOSLIM_RST;
            oofrng_r <= OOFRNG_RST;
            pullin_r <= PULLIN_RST;
            sticky_r <= 9'h000;
            prdata <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) ctrl_r <= {19'h0_0000, pwdata[12:0]};
            if (wr_incfg) incfg_r <= {12'h000, pwdata[19:0]};
            if (wr_prio) prio_r <= {24'h00_0000, pwdata[7:0]};
            if (wr_loslim) loslim_r <= pwdata;
            if (wr_oofrng) oofrng_r <= pwdata & 32'h1fff_1fff;
            if (wr_pullin) pullin_r <= pwdata;
            sticky_r <= sticky_nxt;
            if (setup) prdata <= rdata_nxt;
        end
    end

    assign selected_input = act_r;
    assign lock_lost_flag = mode_r != ST_LOCKED;
    assign holdover_mode = mode_r == ST_HOLDOVER;
    assign freerun_mode = mode_r == ST_FREERUN;
    assign phase_absorb = hit_r;
    assign ramp_switch = (mode_r == ST_ACQUIRE) && ramp_en;
    assign fastlock_bw = (mode_r == ST_ACQUIRE) && fast_en && !ramp_en;
    // reference loss kills outputs unless software keeps them on
    assign outputs_enable = ~los_w[4] | ctrl_r[CTRL_KEEP_OUT];
    assign input_enable = in_en;
    assign input_differential = incfg_r[INCFG_DIFF_LO +: 4];
    assign signal_loss_flag = los_w[3:0];
    assign reference_loss_flag = los_w[4];
    assign frequency_error_flag = oof_w;
endmodule // icsm_top

// ---- bench/icsm_checker.sv ----
`timescale 1ns/100ps
module icsm_checker
    import icsm_pkg::*;
#(
    parameter int PREC_EDGES = 1048576
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input logic pready,
    input logic pslverr,
    input logic [1:0] selected_input,
    input logic lock_lost_flag,
    input logic holdover_mode,
    input logic freerun_mode,
    input logic phase_absorb,
    input logic ramp_switch,
    input logic fastlock_bw,
    input logic outputs_enable,
    input logic reference_loss_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_unmapped: assert property (psel && penable |->
        pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00))
        else $error("error response does not match address");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("error response outside access phase");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("access phase not answered");
    a_mode_exclusive: assert property (!(holdover_mode && freerun_mode))
        else $error("holdover and freerun together");
    a_lock_engaged: assert property (!lock_lost_flag |->
        !holdover_mode && !freerun_mode)
        else $error("lock shown while not engaged");
    a_switch_pulls: assert property ($changed(selected_input) |->
        ##[0:1] lock_lost_flag)
        else $error("input switched without pull-in");
    a_absorb_acq: assert property (phase_absorb |-> lock_lost_flag &&
        !holdover_mode && !freerun_mode)
        else $error("phase absorb outside a switch");
    a_ramp_acq: assert property (ramp_switch |-> lock_lost_flag &&
        !holdover_mode && !freerun_mode)
        else $error("ramp outside a switch");
    a_fast_noramp: assert property (fastlock_bw |->
        !ramp_switch && lock_lost_flag)
        else $error("fast bandwidth with ramp or while locked");
    a_outs_kept: assert property (!reference_loss_flag |-> outputs_enable)
        else $error("outputs off with crystal present");
endmodule // icsm_checker

bind icsm_top icsm_checker #(.PREC_EDGES(PREC_EDGES)) chk_u (.pclk, .presetn,
    .psel, .penable, .paddr, .pready, .pslverr, .selected_input,
    .lock_lost_flag, .holdover_mode, .freerun_mode, .phase_absorb,
    .ramp_switch, .fastlock_bw, .outputs_enable, .reference_loss_flag);

// ---- bench/icsm_clk_src.sv ----
`timescale 1ns/100ps
module icsm_clk_src (
    input wire logic [3:0] run,
    input wire logic xrun,
    output logic [3:0] clk_in,
    output logic xtal
);
    // a stopped source holds its level, like a dead oscillator
    // never gapped: a 10 MHz gapped source is past what pclk can see
    initial begin
        clk_in = 4'h0;
        #13;
        forever #200 clk_in = clk_in ^ run;
    end
    initial begin
        xtal = 1'b0;
        #7;
        forever #150 xtal = xtal ^ xrun;
    end
endmodule // icsm_clk_src

// ---- bench/icsm_tb_top.sv ----
`timescale 1ns/100ps
module icsm_tb_top
    import icsm_pkg::*;
();
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, xrun = 0, xtal;
    logic [1:0] pins = 0, selected_input;
    logic [3:0] run = 0, cin, input_enable, input_differential;
    logic [3:0] signal_loss_flag, frequency_error_flag;
    logic lock_lost_flag, holdover_mode, freerun_mode, phase_absorb;
    logic ramp_switch, fastlock_bw, outputs_enable, reference_loss_flag;
    int fail_count = 0, cmp_count = 0, cyc = 0;

    icsm_top #(.PREC_EDGES(4096)) dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .clock_input_0(cin[0]), .clock_input_1(cin[1]),
        .clock_input_2(cin[2]), .clock_input_3(cin[3]),
        .crystal_reference_pins(xtal), .manual_select_pins(pins),
        .selected_input, .lock_lost_flag, .holdover_mode, .freerun_mode,
        .phase_absorb, .ramp_switch, .fastlock_bw, .outputs_enable,
        .input_enable, .input_differential, .signal_loss_flag,
        .reference_loss_flag, .frequency_error_flag);
    icsm_clk_src src_u (.run, .xrun, .clk_in(cin), .xtal);

    always #25 pclk = ~pclk;

    task conclude();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fail_count++;
            conclude();
        end
    end

    task check(input string name, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // no timeout of its own: pready high or the bench-wide cycle ceiling ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    function logic [31:0] probe(input int k);
        case (k)
            0: return selected_input;
            1: return lock_lost_flag;
            2: return signal_loss_flag;
            3: return holdover_mode;
            4: return outputs_enable;
            5: return reference_loss_flag;
            default: return frequency_error_flag;
        endcase
    endfunction

    // bounded wait, then one compare of the awaited value
    task wait_eq(input string name, input int k, input logic [31:0] exp);
        int n;
        n = 0;
        // long enough for one full precise window on the crystal
        while (probe(k) !== exp && n < 30000) begin
            @(posedge pclk);
            n++;
        end
        check(name, probe(k), exp);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        xfer(0, ICSM_CTRL_OFF, 0);
        check("ctrl", rd, 32'h0000_0080);
        xfer(0, ICSM_INCFG_OFF, 0);
        check("incfg", rd, 32'h0000_0f0f);
        check("in_en", input_enable, 4'hf);
        check("in_diff", input_differential, 4'h0);
        xfer(0, 8'h20, 0);
        check("unmapped_err", err, 32'h0000_0001);
        check("unmapped_rd", rd, 32'h0000_0000);
        // short pull-in keeps every ramped or normal switch quick to settle
        xfer(1, ICSM_PULLIN_OFF, 32'h0010_0010);
        run <= 4'hf;
        xrun <= 1;
        for (int i = 0; i < 4; i++) begin
            pins <= 2'(i);
            wait_eq("pin_sel", 0, i);
            wait_eq("pin_lock", 1, 0);
        end
        xfer(1, ICSM_CTRL_OFF, 32'h0000_0085);
        wait_eq("reg_sel", 0, 2);
        xfer(1, ICSM_PRIO_OFF, 32'h0000_003f);
        xfer(1, ICSM_CTRL_OFF, 32'h0000_00f8);
        wait_eq("zdm_sel", 0, 0);
        wait_eq("zdm_lock", 1, 0);
        check("zdm_hold", selected_input, 2'd0);
        xfer(1, ICSM_CTRL_OFF, 32'h0000_00d8);
        wait_eq("revert", 0, 3);
        wait_eq("rev_lock", 1, 0);
        xfer(1, ICSM_CTRL_OFF, 32'h0000_00c8);
        run <= 4'h7;
        wait_eq("los_live", 2, 4'h8);
        wait_eq("nonrev_move", 0, 0);
        run <= 4'hf;
        wait_eq("los_clear", 2, 4'h0);
        repeat (20) @(posedge pclk);
        check("nonrev_stay", selected_input, 2'd0);
        xfer(0, ICSM_STICKY_OFF, 0);
        check("sticky_set", rd[3:0], 4'h8);
        xfer(1, ICSM_STICKY_OFF, 32'h0000_0008);
        xfer(0, ICSM_STICKY_OFF, 0);
        check("sticky_clr", rd[3:0], 4'h0);
        xfer(1, ICSM_CTRL_OFF, 32'h0000_00d8);
        wait_eq("revert_back", 0, 3);
        run <= 4'h0;
        wait_eq("auto_hold", 3, 1);
        run <= 4'hf;
        xfer(1, ICSM_CTRL_OFF, 32'h0000_0100);
        wait_eq("man_sel", 0, 3);
        wait_eq("fast_lock", 1, 0);
        run <= 4'h7;
        wait_eq("man_hold", 3, 1);
        run <= 4'hf;
        xrun <= 0;
        wait_eq("xtal_los", 5, 1);
        wait_eq("outs_off", 4, 0);
        xfer(1, ICSM_CTRL_OFF, 32'h0000_0300);
        wait_eq("outs_kept", 4, 1);
        xrun <= 1;
        wait_eq("xtal_ok", 5, 0);
        check("oof_off", frequency_error_flag, 4'h0);
        // inputs run at 3/4 of the crystal rate, so each monitor trips
        xfer(1, ICSM_INCFG_OFF, 32'h0000_ff0f);
        wait_eq("oof_prec", 6, 4'hf);
        xfer(0, ICSM_STICKY_OFF, 0);
        check("oof_sticky", rd[8:5], 4'hf);
        xfer(1, ICSM_INCFG_OFF, 32'h000f_0f0f);
        wait_eq("oof_drop", 6, 4'h0);
        wait_eq("oof_fast", 6, 4'hf);
        conclude();
    end
endmodule // icsm_tb_top
